/* File: logic/cca_counter_array.v */
`timescale 1ns/1ps
`include "cca_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Operation
// R1: 16-bit up-counter read and written as separate low and high bytes.
// R2: low-byte read latches high byte; next high-byte read returns that copy.
// R3: byte reads never disturb counting.
// R4: timebase select: div12, div4, timer0, ext falling, sysclk, osc/8.
// R5: external input counts falling edges; source keeps rate at most clk/4.
// R6: external oscillator is synchronised; it must not exceed sysclk.
// R7: wrap from maximum to zero sets the overflow flag.
// R8: overflow flag requests interrupt only with its enable set.
// R9: overflow flag clears only by software write, never on vectoring.
// R10: interrupts pass only with global and array enables both set.
// R11: idle suspend clear lets counting continue during processor idle.
// R12: pwm enable drives 8-bit or 16-bit pwm on channel pin.
// R13: per-channel compare enable switches compare function on or off.
// R14: match enable sets channel flag when counter equals compare register.
// R15: toggle enable inverts channel pin on each counter match.
// R16: toggle plus pwm selects frequency output mode.
// R17: channel flag requests interrupt only with its flag enable set.
// R18: selected pin edge captures counter into compare register, sets flag.
// R19: idle suspend set stops counting during idle, resumes afterwards.
module cca_counter_array (
   // clock and reset
   input  wire       sys_clk_i,
   input  wire       rst_n_i,
   // special function register port
   input  wire [7:0] sfr_addr_i,
   input  wire [7:0] sfr_wdata_i,
   input  wire       sfr_wr_i,
   input  wire       sfr_rd_i,
   output reg  [7:0] sfr_rdata_o,
   // processor state and interrupt enables
   input  wire       cpu_idle_i,
   input  wire       global_irq_enable_i,
   input  wire       array_irq_enable_i,
   output wire       irq_o,
   // count sources
   input  wire       timer0_overflow_i,
   input  wire       external_count_input_i,
   input  wire       ext_osc_i,
   // channel pins
   input  wire [2:0] channel_pin_i,
   output wire [2:0] channel_output_pin_o,
   output wire [2:0] channel_pin_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   reg  [15:0] counter;
   reg  [7:0]  high_snapshot;
   reg  [7:0]  counter_mode_control;
   reg         overflow_flag;
   reg  [2:0]  channel_flag;
   reg  [7:0]  channel0_mode;
   reg  [7:0]  channel1_mode;
   reg  [7:0]  channel2_mode;
   reg         step;

   // timebase state
   reg  [3:0]  div12_cnt;
   reg  [1:0]  div4_cnt;
   reg         ext_in_prev;
   reg         osc_sync1;
   reg         osc_sync2;
   reg         osc_prev;
   reg  [2:0]  osc_div_cnt;
   reg         osc_tick;

   // combinational
   reg         next_tick;
   wire [2:0]  timebase_select;
   wire        idle_suspend;
   wire        overflow_irq_enable;
   wire        run;
   wire        tick;
   wire        wr_cnt_lo;
   wire        wr_cnt_hi;
   wire        wr_status;
   wire        wr_modectl;
   wire [2:0]  flag_set;
   wire [47:0] cc_all;
   wire [23:0] mode_all;
   wire [2:0]  wr_cc_lo;
   wire [2:0]  wr_cc_hi;
   wire [2:0]  flag_irq_enable;
   wire [2:0]  chan_req;
   wire        ovf_req;
   wire        ext_fall;
   wire        osc_rise;

   ////////////////////////////////////////////////////////////////////////
   // field decode
   assign timebase_select     =
      counter_mode_control[`CCA_MC_TB_HI:`CCA_MC_TB_LO];
   assign idle_suspend        = counter_mode_control[`CCA_MC_IDLE_SUSP];
   assign overflow_irq_enable = counter_mode_control[`CCA_MC_OVF_IE];
   assign mode_all            = {channel2_mode, channel1_mode,
                                 channel0_mode};
   assign flag_irq_enable     = {channel2_mode[`CCA_CM_FLAG_IE],
                                 channel1_mode[`CCA_CM_FLAG_IE],
                                 channel0_mode[`CCA_CM_FLAG_IE]};

   // write strobes
   assign wr_cnt_lo  = sfr_wr_i & (sfr_addr_i == `CCA_ADDR_CNT_LO);
   assign wr_cnt_hi  = sfr_wr_i & (sfr_addr_i == `CCA_ADDR_CNT_HI);
   assign wr_status  = sfr_wr_i & (sfr_addr_i == `CCA_ADDR_STATUS);
   assign wr_modectl = sfr_wr_i & (sfr_addr_i == `CCA_ADDR_MODECTL);

   ////////////////////////////////////////////////////////////////////////
   // timebase sources
   assign ext_fall = ext_in_prev & ~external_count_input_i; // R5
   assign osc_rise = osc_sync2 & ~osc_prev;

   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         div12_cnt   <= 4'h0;
         div4_cnt    <= 2'h0;
         ext_in_prev <= 1'b0;
         osc_sync1   <= 1'b0;
         osc_sync2   <= 1'b0;
         osc_prev    <= 1'b0;
         osc_div_cnt <= 3'h0;
         osc_tick    <= 1'b0;
      end else begin
         if (div12_cnt == `CCA_DIV12_LAST) begin
            div12_cnt <= 4'h0;
         end else begin
            div12_cnt <= div12_cnt + 4'h1;
         end
         div4_cnt    <= div4_cnt + 2'h1;
         ext_in_prev <= external_count_input_i;
         osc_sync1   <= ext_osc_i; // R6
         osc_sync2   <= osc_sync1; // R6
         osc_prev    <= osc_sync2;
         osc_tick    <= 1'b0;
         if (osc_rise) begin
            osc_div_cnt <= osc_div_cnt + 3'h1;
            osc_tick    <= (osc_div_cnt == `CCA_OSC8_LAST);
         end
      end
   end

   // timebase select
   always @* begin
      case (timebase_select) // R4
         `CCA_TB_DIV12:  next_tick = (div12_cnt == `CCA_DIV12_LAST);
         `CCA_TB_DIV4:   next_tick = (div4_cnt == `CCA_DIV4_LAST);
         `CCA_TB_TMR0:   next_tick = timer0_overflow_i;
         `CCA_TB_EXTIN:  next_tick = ext_fall;
         `CCA_TB_SYSCLK: next_tick = 1'b1;
         `CCA_TB_OSC8:   next_tick = osc_tick;
         default:        next_tick = 1'b0;
      endcase
   end

   // idle gating
   assign run  = ~(cpu_idle_i & idle_suspend); // R11 R19
   assign tick = next_tick & run;

   ////////////////////////////////////////////////////////////////////////
   // counter
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         counter <= `CCA_RST_WORD;
         step    <= 1'b0;
      end else begin
         step <= tick | wr_cnt_lo | wr_cnt_hi;
         if (wr_cnt_lo) begin
            counter[7:0] <= sfr_wdata_i; // R1
         end else if (wr_cnt_hi) begin
            counter[15:8] <= sfr_wdata_i; // R1
         end else if (tick) begin
            counter <= counter + 16'h0001; // R1 R3
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control and status registers
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         counter_mode_control <= `CCA_RST_BYTE;
         channel0_mode        <= `CCA_RST_BYTE;
         channel1_mode        <= `CCA_RST_BYTE;
         channel2_mode        <= `CCA_RST_BYTE;
      end else if (sfr_wr_i) begin
         case (sfr_addr_i)
            `CCA_ADDR_MODECTL: counter_mode_control <= sfr_wdata_i;
            `CCA_ADDR_CHMODE0: channel0_mode        <= sfr_wdata_i; // R13
            `CCA_ADDR_CHMODE1: channel1_mode        <= sfr_wdata_i; // R13
            `CCA_ADDR_CHMODE2: channel2_mode        <= sfr_wdata_i; // R13
            default: ;
         endcase
      end
   end

   // flags: hardware set wins over software write
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         overflow_flag <= 1'b0;
         channel_flag  <= 3'h0;
      end else begin
         if (tick & ~wr_cnt_lo & ~wr_cnt_hi &
             (counter == `CCA_CNT_MAX)) begin
            overflow_flag <= 1'b1; // R7
         end else if (wr_status) begin
            overflow_flag <= sfr_wdata_i[`CCA_ST_OVF]; // R9
         end
         if (wr_status) begin
            channel_flag <= flag_set | sfr_wdata_i[2:0];
         end else begin
            channel_flag <= flag_set | channel_flag;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o   <= `CCA_RST_BYTE;
         high_snapshot <= `CCA_RST_BYTE;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            `CCA_ADDR_CNT_LO: begin
               sfr_rdata_o   <= counter[7:0];
               high_snapshot <= counter[15:8]; // R2
            end
            `CCA_ADDR_CNT_HI:  sfr_rdata_o <= high_snapshot; // R2
            `CCA_ADDR_STATUS:  sfr_rdata_o <= {overflow_flag, 4'h0,
                                              channel_flag};
            `CCA_ADDR_MODECTL: sfr_rdata_o <= counter_mode_control;
            `CCA_ADDR_CHMODE0: sfr_rdata_o <= channel0_mode;
            `CCA_ADDR_CHMODE1: sfr_rdata_o <= channel1_mode;
            `CCA_ADDR_CHMODE2: sfr_rdata_o <= channel2_mode;
            `CCA_ADDR_CC_BASE: sfr_rdata_o <= cc_all[7:0];
            `CCA_ADDR_CC_BASE + 8'h01: sfr_rdata_o <= cc_all[15:8];
            `CCA_ADDR_CC_BASE + 8'h02: sfr_rdata_o <= cc_all[23:16];
            `CCA_ADDR_CC_BASE + 8'h03: sfr_rdata_o <= cc_all[31:24];
            `CCA_ADDR_CC_BASE + 8'h04: sfr_rdata_o <= cc_all[39:32];
            `CCA_ADDR_CC_BASE + 8'h05: sfr_rdata_o <= cc_all[47:40];
            default: sfr_rdata_o <= `CCA_RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
         assign wr_cc_lo[gi] = sfr_wr_i & (sfr_addr_i ==
            `CCA_ADDR_CC_BASE + (gi * 2));
         assign wr_cc_hi[gi] = sfr_wr_i & (sfr_addr_i ==
            `CCA_ADDR_CC_BASE + (gi * 2) + 1);
         cca_channel u_chan (
            .sys_clk_i  (sys_clk_i),
            .rst_n_i    (rst_n_i),
            .cnt_i      (counter),
            .step_i     (step),
            .mode_i     (mode_all[gi*8 +: 8]),
            .wr_lo_i    (wr_cc_lo[gi]),
            .wr_hi_i    (wr_cc_hi[gi]),
            .wdata_i    (sfr_wdata_i),
            .cc_o       (cc_all[gi*16 +: 16]),
            .flag_set_o (flag_set[gi]),
            .pin_i      (channel_pin_i[gi]),
            .pin_o      (channel_output_pin_o[gi]),
            .pin_oe_o   (channel_pin_oe_o[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // interrupt request
   assign ovf_req  = overflow_flag & overflow_irq_enable; // R8
   assign chan_req = channel_flag & flag_irq_enable; // R17
   assign irq_o    = global_irq_enable_i & array_irq_enable_i &
                     (ovf_req | (|chan_req)); // R10

endmodule // cca_counter_array

/* File: logic/cca_defs.vh */
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH
// special function register addresses
`define CCA_ADDR_STATUS   8'hD8
`define CCA_ADDR_MODECTL  8'hD9
`define CCA_ADDR_CHMODE0  8'hDA
`define CCA_ADDR_CHMODE1  8'hDB
`define CCA_ADDR_CHMODE2  8'hDC
`define CCA_ADDR_CC_BASE  8'hE9
`define CCA_ADDR_CNT_LO   8'hF9
`define CCA_ADDR_CNT_HI   8'hFA
// reset values
`define CCA_RST_BYTE      8'h00
`define CCA_RST_WORD      16'h0000
// counter_mode_control fields
`define CCA_MC_IDLE_SUSP  7
`define CCA_MC_TB_HI      3
`define CCA_MC_TB_LO      1
`define CCA_MC_OVF_IE     0
// status fields
`define CCA_ST_OVF        7
// channel_mode fields
`define CCA_CM_WIDE       7
`define CCA_CM_COMP       6
`define CCA_CM_RISE       5
`define CCA_CM_FALL       4
`define CCA_CM_MATCH      3
`define CCA_CM_TOGGLE     2
`define CCA_CM_PWM        1
`define CCA_CM_FLAG_IE    0
// timebase codes
`define CCA_TB_DIV12      3'h0
`define CCA_TB_DIV4       3'h1
`define CCA_TB_TMR0       3'h2
`define CCA_TB_EXTIN      3'h3
`define CCA_TB_SYSCLK     3'h4
`define CCA_TB_OSC8       3'h5
// divider and counter terminal counts
`define CCA_DIV12_LAST    4'hB
`define CCA_DIV4_LAST     2'h3
`define CCA_OSC8_LAST     3'h7
`define CCA_CNT_MAX       16'hFFFF
`endif

/* File: logic/cca_channel.v */
`timescale 1ns/1ps
`include "cca_defs.vh"

module cca_channel (
   // clock and reset
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   // counter
   input  wire [15:0] cnt_i,
   input  wire        step_i,
   // register access
   input  wire [7:0]  mode_i,
   input  wire        wr_lo_i,
   input  wire        wr_hi_i,
   input  wire [7:0]  wdata_i,
   output wire [15:0] cc_o,
   output reg         flag_set_o,
   // channel pin
   input  wire        pin_i,
   output reg         pin_o,
   output wire        pin_oe_o
);

   reg  [15:0] cc;
   reg         pin_prev;
   wire        comp_en = mode_i[`CCA_CM_COMP];
   wire        tog     = mode_i[`CCA_CM_TOGGLE];
   wire        pwm     = mode_i[`CCA_CM_PWM];
   wire        freq    = tog & pwm;
   wire        hit     = freq ? (cnt_i[7:0] == cc[7:0]) : (cnt_i == cc);
   wire        match_ev = step_i & comp_en & hit;
   wire        cap_ev  = (mode_i[`CCA_CM_RISE] & pin_i & ~pin_prev) |
                         (mode_i[`CCA_CM_FALL] & ~pin_i & pin_prev);
   wire        pwm_lvl = mode_i[`CCA_CM_WIDE] ? (cnt_i >= cc) :
                         (cnt_i[7:0] >= cc[7:0]);

   assign cc_o     = cc;
   assign pin_oe_o = comp_en & (tog | pwm);

   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cc         <= `CCA_RST_WORD;
         pin_prev   <= 1'b0;
         pin_o      <= 1'b0;
         flag_set_o <= 1'b0;
      end else begin
         pin_prev   <= pin_i;
         flag_set_o <= (match_ev & mode_i[`CCA_CM_MATCH]) | cap_ev; // R14
         if (cap_ev) begin
            cc <= cnt_i; // R18
         end else if (wr_lo_i) begin
            cc[7:0] <= wdata_i;
         end else if (wr_hi_i) begin
            cc[15:8] <= wdata_i;
         end else if (match_ev & freq) begin
            cc[7:0] <= cc[7:0] + cc[15:8]; // R16
         end
         if (comp_en & pwm & ~tog) begin
            pin_o <= pwm_lvl; // R12
         end else if (match_ev & tog) begin
            pin_o <= ~pin_o; // R15
         end
      end
   end

endmodule // cca_channel

/* File: verif/cca_pin_model.sv */
`timescale 1ns/1ps

module cca_pin_model (
   // clock
   input  wire       sys_clk_i,
   // pins toward the block
   output reg        ext_count_o,
   output reg        ext_osc_o,
   output reg  [2:0] chan_pin_o
);
   integer k;

   initial begin
      ext_count_o = 1'b1;
      ext_osc_o   = 1'b0;
      chan_pin_o  = 3'h0;
   end

   // falling edges at a quarter of the clock rate at most
   task ext_edges(input integer n);
      for (k = 0; k < n; k = k + 1) begin
         repeat (2) @(posedge sys_clk_i);
         ext_count_o <= 1'b0;
         repeat (2) @(posedge sys_clk_i);
         ext_count_o <= 1'b1;
      end
   endtask

   // oscillator well below the clock rate, still between runs
   task osc_edges(input integer n);
      for (k = 0; k < n; k = k + 1) begin
         repeat (2) @(posedge sys_clk_i);
         ext_osc_o <= 1'b1;
         repeat (2) @(posedge sys_clk_i);
         ext_osc_o <= 1'b0;
      end
   endtask

   task set_pin(input integer ch, input v);
      begin
         @(posedge sys_clk_i);
         chan_pin_o[ch] <= v;
      end
   endtask
endmodule // cca_pin_model

/* File: verif/cca_counter_array_asserts.sv */
`timescale 1ns/1ps

module cca_counter_array_asserts (
   // clock and reset
   input wire       sys_clk_i,
   input wire       rst_n_i,
   // register port
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire       sfr_wr_i,
   input wire       sfr_rd_i,
   input wire [7:0] sfr_rdata_o,
   // state, interrupt and pins
   input wire       cpu_idle_i,
   input wire       global_irq_enable_i,
   input wire       array_irq_enable_i,
   input wire       irq_o,
   input wire [2:0] channel_output_pin_o,
   input wire [2:0] channel_pin_oe_o
);
   reg  [7:0] mc;
   reg  [7:0] m0;
   reg  [7:0] m1;
   reg  [7:0] m2;
   wire       rd_lo = sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hF9;
   wire       run   = mc[3:1] == 3'h4 && !(cpu_idle_i && mc[7]);

   // shadow of the control registers
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mc <= 8'h00;
         m0 <= 8'h00;
         m1 <= 8'h00;
         m2 <= 8'h00;
      end else if (sfr_wr_i) begin
         if (sfr_addr_i == 8'hD9) mc <= sfr_wdata_i;
         if (sfr_addr_i == 8'hDA) m0 <= sfr_wdata_i;
         if (sfr_addr_i == 8'hDB) m1 <= sfr_wdata_i;
         if (sfr_addr_i == 8'hDC) m2 <= sfr_wdata_i;
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_irq_gate;
      irq_o |-> global_irq_enable_i && array_irq_enable_i;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq without both enables");
   property p_irq_src;
      irq_o |-> mc[0] || m0[0] || m1[0] || m2[0];
   endproperty
   a_irq_src: assert property (p_irq_src)
      else $error("irq with every source masked");
   property p_irq_hold;
      irq_o && !sfr_wr_i ##1 global_irq_enable_i && array_irq_enable_i
         |-> irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without a write");
   property p_oe_off;
      (channel_pin_oe_o & ~{m2[6], m1[6], m0[6]}) == 3'h0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("pin driven with compare off");
   property p_oe_on;
      m0[6] && (m0[2] || m0[1]) |-> channel_pin_oe_o[0];
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("pin not driven in output mode");
   property p_step;
      rd_lo && run ##1 rd_lo |=> sfr_rdata_o == $past(sfr_rdata_o) + 8'h01;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step by one");
   property p_hold;
      rd_lo && mc[7] && cpu_idle_i ##1 rd_lo |=> $stable(sfr_rdata_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("counter moved while suspended");
   property p_mode_rd;
      sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hDA |=> sfr_rdata_o == m0;
   endproperty
   a_mode_rd: assert property (p_mode_rd)
      else $error("mode readback differs");

   c_irq: cover property (irq_o);
   c_toggle: cover property ($changed(channel_output_pin_o[0]));
   c_step: cover property (rd_lo && run ##1 rd_lo);
endmodule // cca_counter_array_asserts

bind cca_counter_array cca_counter_array_asserts i_chk (
   .sys_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i,
   .sfr_rdata_o, .cpu_idle_i, .global_irq_enable_i, .array_irq_enable_i,
   .irq_o, .channel_output_pin_o, .channel_pin_oe_o);

/* File: verif/test_cca_counter_array.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count = check_count + 1; if ((a) !== (e)) \
begin n_errors = n_errors + 1; \
$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module test_cca_counter_array;
   reg        sys_clk_i = 1'b0;
   reg        rst_n_i = 1'b0;
   reg  [7:0] sfr_addr_i = 8'h00;
   reg  [7:0] sfr_wdata_i = 8'h00;
   reg        sfr_wr_i = 1'b0;
   reg        sfr_rd_i = 1'b0;
   reg        idle = 1'b0;
   reg        glob = 1'b0;
   reg        arr = 1'b0;
   reg        t0 = 1'b0;
   wire       ext_in;
   wire       osc;
   wire [2:0] cpin;
   wire [7:0] rdata;
   wire       irq;
   wire [2:0] pin;
   wire [2:0] oe;
   integer    n_errors = 0;
   integer    check_count = 0;

   cca_counter_array i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(rdata),
      .cpu_idle_i(idle), .global_irq_enable_i(glob),
      .array_irq_enable_i(arr), .irq_o(irq), .timer0_overflow_i(t0),
      .external_count_input_i(ext_in), .ext_osc_i(osc),
      .channel_pin_i(cpin), .channel_output_pin_o(pin),
      .channel_pin_oe_o(oe));
   cca_pin_model i_pins (.sys_clk_i(sys_clk_i), .ext_count_o(ext_in),
      .ext_osc_o(osc), .chan_pin_o(cpin));

   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge sys_clk_i);
         sfr_wr_i <= 1'b1;
         sfr_addr_i <= a;
         sfr_wdata_i <= d;
         @(posedge sys_clk_i);
         sfr_wr_i <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge sys_clk_i);
         sfr_rd_i <= 1'b1;
         sfr_addr_i <= a;
         @(posedge sys_clk_i);
         sfr_rd_i <= 1'b0;
         #1 d = rdata;
      end
   endtask
   // two low-byte reads on consecutive cycles
   task rd2(output [7:0] d1, output [7:0] d2);
      begin
         @(posedge sys_clk_i);
         sfr_rd_i <= 1'b1;
         sfr_addr_i <= 8'hF9;
         @(posedge sys_clk_i);
         #1 d1 = rdata;
         @(posedge sys_clk_i);
         sfr_rd_i <= 1'b0;
         #1 d2 = rdata;
      end
   endtask
   task set_cnt(input [7:0] hi, input [7:0] lo);
      begin
         wr(8'hD9, 8'h0C);
         wr(8'hFA, hi);
         wr(8'hF9, lo);
      end
   endtask
   task tb_range(input [2:0] c, input integer n, input [7:0] lo, hi);
      reg [7:0] v;
      begin
         set_cnt(8'h00, 8'h00);
         wr(8'hD9, {4'h0, c, 1'b0});
         repeat (n) @(posedge sys_clk_i);
         wr(8'hD9, 8'h0C);
         rd(8'hF9, v);
         `CHK(v >= lo && v <= hi, 1'b1)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task t_regs;
      reg [7:0] v;
      begin
         rd(8'hDC, v);
         `CHK(v, 8'h00)
         wr(8'hDB, 8'hA5);
         rd(8'hDB, v);
         `CHK(v, 8'hA5)
         wr(8'hDB, 8'h00);
         rd(8'h80, v);
         `CHK(v, 8'h00)
      end
   endtask
   task t_snap;
      reg [7:0] a;
      reg [7:0] b;
      begin
         set_cnt(8'h12, 8'hFF);
         rd(8'hF9, a);
         `CHK(a, 8'hFF)
         wr(8'hD9, 8'h08);
         repeat (4) @(posedge sys_clk_i);
         rd(8'hFA, a);
         `CHK(a, 8'h12)
         rd2(a, b);
         `CHK(b, a + 8'h01)
      end
   endtask
   task t_ovf;
      reg [7:0] v;
      begin
         @(posedge sys_clk_i);
         glob <= 1'b1;
         set_cnt(8'hFF, 8'hF0);
         wr(8'hD9, 8'h09);
         repeat (30) @(posedge sys_clk_i);
         rd(8'hD8, v);
         `CHK(v[7], 1'b1)
         `CHK(irq, 1'b0)
         @(posedge sys_clk_i);
         arr <= 1'b1;
         @(posedge sys_clk_i);
         #1 `CHK(irq, 1'b1)
         wr(8'hD9, 8'h08);
         `CHK(irq, 1'b0)
         wr(8'hD9, 8'h09);
         repeat (10) @(posedge sys_clk_i);
         #1 `CHK(irq, 1'b1)
         @(posedge sys_clk_i);
         glob <= 1'b0;
         @(posedge sys_clk_i);
         #1 `CHK(irq, 1'b0)
         wr(8'hD8, 8'h00);
         rd(8'hD8, v);
         `CHK(v[7], 1'b0)
      end
   endtask
   task t_idle;
      reg [7:0] a;
      reg [7:0] b;
      begin
         wr(8'hD9, 8'h08);
         @(posedge sys_clk_i);
         idle <= 1'b1;
         rd2(a, b);
         `CHK(b, a + 8'h01)
         wr(8'hD9, 8'h88);
         rd2(a, b);
         `CHK(b, a)
         @(posedge sys_clk_i);
         idle <= 1'b0;
         rd2(a, b);
         `CHK(b, a + 8'h01)
      end
   endtask
   task t_timebase;
      reg [7:0] v;
      begin
         tb_range(3'h0, 120, 8'd9, 8'd11);
         tb_range(3'h1, 120, 8'd29, 8'd32);
         tb_range(3'h4, 20, 8'd20, 8'd24);
         tb_range(3'h2, 1, 8'd0, 8'd0);
         wr(8'hD9, 8'h04);
         repeat (5) begin
            @(posedge sys_clk_i);
            t0 <= 1'b1;
            @(posedge sys_clk_i);
            t0 <= 1'b0;
         end
         rd(8'hF9, v);
         `CHK(v, 8'h05)
         tb_range(3'h3, 1, 8'd0, 8'd0);
         wr(8'hD9, 8'h06);
         i_pins.ext_edges(6);
         repeat (4) @(posedge sys_clk_i);
         rd(8'hF9, v);
         `CHK(v, 8'h06)
         tb_range(3'h5, 1, 8'd0, 8'd0);
         wr(8'hD9, 8'h0A);
         i_pins.osc_edges(24);
         repeat (8) @(posedge sys_clk_i);
         rd(8'hF9, v);
         `CHK(v, 8'h03)
      end
   endtask
   task t_match;
      reg [7:0] v;
      reg       p;
      begin
         @(posedge sys_clk_i);
         glob <= 1'b1;
         set_cnt(8'h00, 8'h00);
         wr(8'hE9, 8'h20);
         wr(8'hEA, 8'h00);
         wr(8'hDA, 8'h4D);
         p = pin[0];
         wr(8'hD9, 8'h08);
         repeat (60) @(posedge sys_clk_i);
         wr(8'hD9, 8'h0C);
         `CHK(pin[0], ~p)
         rd(8'hD8, v);
         `CHK(v[0], 1'b1)
         `CHK(irq, 1'b1)
         wr(8'hDA, 8'h4C);
         `CHK(irq, 1'b0)
         wr(8'hD8, 8'h00);
         wr(8'hDA, 8'h0C);
         `CHK(oe[0], 1'b0)
         set_cnt(8'h00, 8'h00);
         wr(8'hD9, 8'h08);
         repeat (60) @(posedge sys_clk_i);
         rd(8'hD8, v);
         `CHK(v[0], 1'b0)
         @(posedge sys_clk_i);
         glob <= 1'b0;
      end
   endtask
   task t_freq;
      reg [7:0] v;
      reg       p;
      begin
         set_cnt(8'h00, 8'h00);
         wr(8'hE9, 8'h10);
         wr(8'hEA, 8'h10);
         wr(8'hDA, 8'h46);
         p = pin[0];
         wr(8'hD9, 8'h08);
         repeat (54) @(posedge sys_clk_i);
         wr(8'hD9, 8'h0C);
         rd(8'hE9, v);
         `CHK(v, 8'h40)
         `CHK(pin[0], ~p)
         wr(8'hDA, 8'h00);
      end
   endtask
   task t_pwm;
      integer h;
      begin
         set_cnt(8'h00, 8'h00);
         wr(8'hE9, 8'h80);
         wr(8'hEA, 8'h01);
         wr(8'hDA, 8'h42);
         wr(8'hD9, 8'h08);
         h = 0;
         repeat (256) @(posedge sys_clk_i) h = h + pin[0];
         `CHK(h >= 126 && h <= 130, 1'b1)
         set_cnt(8'h00, 8'h00);
         wr(8'hDA, 8'hC2);
         wr(8'hD9, 8'h08);
         h = 0;
         repeat (256) @(posedge sys_clk_i) h = h + pin[0];
         `CHK(h, 0)
         wr(8'hDA, 8'h00);
      end
   endtask
   task t_cap;
      reg [7:0] v;
      begin
         set_cnt(8'h34, 8'h56);
         wr(8'hDB, 8'h21);
         i_pins.set_pin(1, 1'b1);
         repeat (4) @(posedge sys_clk_i);
         rd(8'hEB, v);
         `CHK(v, 8'h56)
         rd(8'hEC, v);
         `CHK(v, 8'h34)
         rd(8'hD8, v);
         `CHK(v[1], 1'b1)
         set_cnt(8'h00, 8'h9A);
         wr(8'hDB, 8'h11);
         i_pins.set_pin(1, 1'b0);
         repeat (4) @(posedge sys_clk_i);
         rd(8'hEB, v);
         `CHK(v, 8'h9A)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      begin
         $display("errors %0d checks %0d", n_errors, check_count);
         if (n_errors == 0 && check_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   initial begin
      #400000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end

   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_snap;
      t_ovf;
      t_idle;
      t_timebase;
      t_match;
      t_pwm;
      t_freq;
      t_cap;
      tally_and_finish;
   end
endmodule // test_cca_counter_array
